// [pe_query_resp.v]
// Notes on behaviour
// (R1) blank query: opcode Ah, length 3h, sizes
// (R2) programmer keeps sizes within memory limits
// (R3) blank check from address zero upward
// (R4) blank gives F0h, otherwise 0Fh
// (R5) system configuration bits never checked
// (R6) version query: opcode Bh, length 1h
// (R7) version byte: major high, revision low
// (R8) one response per received command
// (R9) response opcode 1h pass, 2h fail
// (R10) unknown opcode answered with 3h
// (R11) two-word header, query byte low
// (R12) echo processed opcode in header
// (R13) one command at a time
// (R14) queries always pass with result byte
// (R15) error byte 0h, 1h verify, 2h other
// (R16) length counts words including header
// (R17) responses two words except code read
// (R18) code read length from instruction count
// (R19) header, length, then data in order
`timescale 1ns/1ps
`default_nettype none
`include "pe_defines.vh"

module pe_query_resp #(
    parameter [15:0] KNOWN_OPCODES = `PE_KNOWN_OPCODES,
    parameter [7:0] VERSION = `PE_VERSION
) (
    input wire clk_sys,
    input wire nrst,
    input wire linkClk,
    input wire linkDataIn,
    output wire linkDataOut,
    output wire linkDataOe,
    input wire globalCodeProtect,
    input wire globalWriteProtect,
    output reg codeRdReq,
    output reg [23:0] codeRdAddr,
    input wire [23:0] codeRdData,
    input wire codeRdValid,
    output reg execStart,
    output reg [3:0] execOpcode,
    output reg [15:0] cmdWord,
    output reg cmdWordValid,
    input wire execDone,
    input wire [1:0] execStatus,
    output reg respDataReq,
    input wire [15:0] respData,
    input wire respDataValid,
    output reg busyOut
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ARGS = 3'h1;
    localparam [2:0] ST_DECIDE = 3'h2;
    localparam [2:0] ST_BLANK = 3'h3;
    localparam [2:0] ST_EXEC = 3'h4;
    localparam [2:0] ST_SEND = 3'h5;

    // link clock and data pass two flops before any logic looks at them
    // third flop feeds only the edge detector
    reg linkClkS1;
    reg linkClkS2;
    reg linkClkS3;
    reg linkDataS1;
    reg linkDataS2;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            linkClkS1 <= 1'b0;
            linkClkS2 <= 1'b0;
            linkClkS3 <= 1'b0;
            linkDataS1 <= 1'b0;
            linkDataS2 <= 1'b0;
        end else begin
            linkClkS1 <= linkClk;
            linkClkS2 <= linkClkS1;
            linkClkS3 <= linkClkS2;
            linkDataS1 <= linkDataIn;
            linkDataS2 <= linkDataS1;
        end
    end

    wire linkRise = linkClkS2 && !linkClkS3;
    wire linkFall = !linkClkS2 && linkClkS3;

    reg [2:0] state_reg;
    reg [3:0] opcode_reg;
    reg [11:0] wordsLeft_reg;
    reg [1:0] argIdx_reg;
    reg [15:0] arg1_reg;
    reg [15:0] arg2_reg;
    reg [3:0] respOp_reg;
    reg [7:0] qe_reg;
    reg [15:0] respLen_reg;
    reg [15:0] sent_reg;
    reg [15:0] blankCnt_reg;
    reg blankOk_reg;
    reg memPend_reg;
    reg dataPend_reg;
    reg txLoad_reg;
    reg [15:0] txWord_reg;

    // link bits during work or answer are dropped
    wire rxEnable = (state_reg == ST_IDLE) || (state_reg == ST_ARGS); // (R13)
    wire [15:0] rxWord;
    wire rxWordValid;
    wire txBusy;

    pe_word_rx #(
        .WIDTH(16)
    ) rxUnit (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(rxEnable),
        .linkRise(linkRise),
        .linkBit(linkDataS2),
        .rxWord(rxWord),
        .rxWordValid(rxWordValid)
    );

    pe_word_tx #(
        .WIDTH(16)
    ) txUnit (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(txLoad_reg),
        .word(txWord_reg),
        .linkFall(linkFall),
        .linkOut(linkDataOut),
        .linkOe(linkDataOe),
        .busy(txBusy)
    );

    // queries are decoded first; their bits are don't-care
    function isKnown;
        input [3:0] op;
        begin
            isKnown = KNOWN_OPCODES[op];
        end
    endfunction

    // code read of n instructions, packed three words per two instructions
    function [15:0] readCodeLen;
        input [15:0] n;
        reg [16:0] nEven;
        reg [17:0] total;
        begin
            nEven = {1'b0, n} + {16'h0000, n[0]};
            total = {1'b0, nEven} + {2'b00, nEven[16:1]} + {2'b00, `PE_HDR_WORDS};
            readCodeLen = total[15:0]; // (R18)
        end
    endfunction

    // verify failure is only meaningful for the row and user id programming
    function [7:0] errorByte;
        input [3:0] op;
        input [1:0] stat;
        begin
            if (stat == `PE_STAT_OK) begin
                errorByte = `PE_QE_NO_ERROR;
            end else if (stat == `PE_STAT_VERIFY_FAIL &&
                         (op == `PE_OP_PROG_ROW || op == `PE_OP_PROG_USER_ID)) begin
                errorByte = `PE_QE_VERIFY_FAIL;
            end else begin
                errorByte = `PE_QE_OTHER_ERROR;
            end
        end
    endfunction

    wire [11:0] rxLenField = rxWord[11:0];
    wire cmdLastWord = (wordsLeft_reg == 12'h001);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            opcode_reg <= 4'h0;
            wordsLeft_reg <= 12'h000;
            argIdx_reg <= 2'h0;
            arg1_reg <= 16'h0000;
            arg2_reg <= 16'h0000;
            respOp_reg <= 4'h0;
            qe_reg <= 8'h00;
            respLen_reg <= 16'h0000;
            sent_reg <= 16'h0000;
            blankCnt_reg <= 16'h0000;
            blankOk_reg <= 1'b0;
            memPend_reg <= 1'b0;
            dataPend_reg <= 1'b0;
            txLoad_reg <= 1'b0;
            txWord_reg <= 16'h0000;
            codeRdReq <= 1'b0;
            codeRdAddr <= 24'h000000;
            execStart <= 1'b0;
            execOpcode <= 4'h0;
            cmdWord <= 16'h0000;
            cmdWordValid <= 1'b0;
            respDataReq <= 1'b0;
            busyOut <= 1'b0;
        end else begin
            txLoad_reg <= 1'b0;
            codeRdReq <= 1'b0;
            execStart <= 1'b0;
            cmdWordValid <= 1'b0;
            respDataReq <= 1'b0;
            busyOut <= !(state_reg == ST_IDLE);
            case (state_reg)
                ST_IDLE: begin
                    if (rxWordValid) begin
                        opcode_reg <= rxWord[15:12];
                        cmdWord <= rxWord;
                        cmdWordValid <= 1'b1;
                        argIdx_reg <= 2'h1;
                        // no stale sizes from the last command
                        arg1_reg <= 16'h0000;
                        arg2_reg <= 16'h0000;
                        // a zero length is taken as a single word command
                        if (rxLenField <= 12'h001) begin
                            wordsLeft_reg <= 12'h000;
                            state_reg <= ST_DECIDE;
                        end else begin
                            wordsLeft_reg <= rxLenField - 12'h001;
                            state_reg <= ST_ARGS;
                        end
                    end
                end
                ST_ARGS: begin
                    if (rxWordValid) begin
                        cmdWord <= rxWord;
                        cmdWordValid <= 1'b1;
                        // later words reach the executor via cmdWord
                        if (argIdx_reg == 2'h1) begin
                            arg1_reg <= rxWord; // (R1)
                        end
                        if (argIdx_reg == 2'h2) begin
                            arg2_reg <= rxWord;
                        end
                        if (argIdx_reg != 2'h3) begin
                            argIdx_reg <= argIdx_reg + 2'h1;
                        end
                        wordsLeft_reg <= wordsLeft_reg - 12'h001;
                        if (cmdLastWord) begin
                            state_reg <= ST_DECIDE;
                        end
                    end
                end
                ST_DECIDE: begin
                    sent_reg <= 16'h0000;
                    respLen_reg <= `PE_HDR_WORDS; // (R16) (R17)
                    if (opcode_reg == `PE_OP_BLANK_QUERY) begin
                        // only the two global protect bits join the check (R5)
                        blankOk_reg <= globalCodeProtect && globalWriteProtect; // (R4)
                        blankCnt_reg <= 16'h0000;
                        codeRdAddr <= `PE_CODE_ADDR_START; // (R3)
                        memPend_reg <= 1'b0;
                        state_reg <= ST_BLANK;
                    end else if (opcode_reg == `PE_OP_VERSION_QUERY) begin
                        respOp_reg <= `PE_RESP_PASS; // (R14)
                        qe_reg <= VERSION; // (R6) (R7)
                        state_reg <= ST_SEND;
                    end else if (isKnown(opcode_reg)) begin
                        execStart <= 1'b1;
                        execOpcode <= opcode_reg;
                        state_reg <= ST_EXEC;
                    end else begin
                        // its words were all consumed; link stays in step
                        respOp_reg <= `PE_RESP_NACK; // (R10)
                        qe_reg <= `PE_QE_NO_ERROR;
                        state_reg <= ST_SEND;
                    end
                end
                ST_BLANK: begin
                    // one read in flight; address moves on its answer
                    // size is trusted to fit the memory; no bounds check here (R2)
                    if (blankCnt_reg == arg1_reg && !memPend_reg) begin
                        respOp_reg <= `PE_RESP_PASS; // (R14)
                        qe_reg <= blankOk_reg ? `PE_QE_BLANK : `PE_QE_NOT_BLANK; // (R4)
                        state_reg <= ST_SEND;
                    end else if (!memPend_reg) begin
                        codeRdReq <= 1'b1;
                        memPend_reg <= 1'b1;
                    end else if (codeRdValid) begin
                        memPend_reg <= 1'b0;
                        blankCnt_reg <= blankCnt_reg + 16'h0001;
                        codeRdAddr <= codeRdAddr + 24'h000002; // (R3)
                        if (codeRdData != 24'hffffff) begin
                            blankOk_reg <= 1'b0; // (R4)
                        end
                    end
                end
                ST_EXEC: begin
                    if (execDone) begin
                        if (execStatus == `PE_STAT_OK) begin
                            respOp_reg <= `PE_RESP_PASS; // (R9)
                        end else begin
                            respOp_reg <= `PE_RESP_FAIL; // (R9)
                        end
                        qe_reg <= errorByte(opcode_reg, execStatus); // (R15)
                        // a failed read has no data words
                        if (opcode_reg == `PE_OP_READ_CODE && execStatus == `PE_STAT_OK) begin
                            respLen_reg <= readCodeLen(arg1_reg); // (R18)
                        end
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // load pulse covers the cycle before busy rises
                    if (!txBusy && !txLoad_reg) begin
                        if (sent_reg == 16'h0000) begin
                            // opcode, echoed command, query byte (R11) (R12)
                            txWord_reg <= {respOp_reg, opcode_reg, qe_reg};
                            txLoad_reg <= 1'b1;
                            sent_reg <= 16'h0001; // (R19)
                        end else if (sent_reg == 16'h0001) begin
                            txWord_reg <= respLen_reg; // (R16)
                            txLoad_reg <= 1'b1;
                            sent_reg <= 16'h0002; // (R19)
                        end else if (sent_reg == respLen_reg) begin
                            // new commands are only heard once the answer is out (R8) (R13)
                            state_reg <= ST_IDLE;
                        end else if (!dataPend_reg) begin
                            // one data word fetched at a time
                            respDataReq <= 1'b1;
                            dataPend_reg <= 1'b1;
                        end else if (respDataValid) begin
                            txWord_reg <= respData;
                            txLoad_reg <= 1'b1;
                            dataPend_reg <= 1'b0;
                            sent_reg <= sent_reg + 16'h0001; // (R19)
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // pe_query_resp

`default_nettype wire

// [pe_defines.vh]
`ifndef PE_DEFINES_VH
`define PE_DEFINES_VH

// command opcodes, bits 15:12 of the first command word
`define PE_OP_READ_CODE 4'h2
`define PE_OP_PROG_USER_ID 4'h4
`define PE_OP_PROG_ROW 4'h5
`define PE_OP_BLANK_QUERY 4'ha
`define PE_OP_VERSION_QUERY 4'hb

// opcodes this executive recognises, one bit per opcode
`define PE_KNOWN_OPCODES 16'hfcff

// fixed command lengths of the two queries
`define PE_LEN_BLANK_QUERY 12'h003
`define PE_LEN_VERSION_QUERY 12'h001

// response opcodes
`define PE_RESP_PASS 4'h1
`define PE_RESP_FAIL 4'h2
`define PE_RESP_NACK 4'h3

// query and error byte values
`define PE_QE_BLANK 8'hf0
`define PE_QE_NOT_BLANK 8'h0f
`define PE_QE_NO_ERROR 8'h00
`define PE_QE_VERIFY_FAIL 8'h01
`define PE_QE_OTHER_ERROR 8'h02

// executor status codes
`define PE_STAT_OK 2'h0
`define PE_STAT_VERIFY_FAIL 2'h1

// header length of every response, in words
`define PE_HDR_WORDS 16'h0002

// field positions in the first response word
`define PE_FLD_OPCODE_MSB 15
`define PE_FLD_OPCODE_LSB 12
`define PE_FLD_QE_MSB 7

// version byte, value arbitrary
`define PE_VERSION 8'h10

// code memory addresses step by two per instruction word
`define PE_CODE_ADDR_START 24'h000000

`endif

// [pe_word_rx.v]
`timescale 1ns/1ps
`default_nettype none

module pe_word_rx #(
    parameter WIDTH = 16
) (
    input wire clk_sys,
    input wire nrst,
    input wire enable,
    input wire linkRise,
    input wire linkBit,
    output reg [WIDTH-1:0] rxWord,
    output reg rxWordValid
);

    reg [WIDTH-1:0] shiftReg;
    reg [4:0] countReg;

    // words arrive msb first, one bit per rising link clock edge
    always @(posedge clk_sys) begin
        if (!nrst) begin
            shiftReg <= {WIDTH{1'b0}};
            countReg <= 5'h00;
            rxWord <= {WIDTH{1'b0}};
            rxWordValid <= 1'b0;
        end else begin
            rxWordValid <= 1'b0;
            if (!enable) begin
                countReg <= 5'h00;
            end else if (linkRise) begin
                shiftReg <= {shiftReg[WIDTH-2:0], linkBit};
                if (countReg == WIDTH - 1) begin
                    countReg <= 5'h00;
                    rxWord <= {shiftReg[WIDTH-2:0], linkBit};
                    rxWordValid <= 1'b1;
                end else begin
                    countReg <= countReg + 5'h01;
                end
            end
        end
    end

endmodule // pe_word_rx

`default_nettype wire

// [pe_word_tx.v]
`timescale 1ns/1ps
`default_nettype none

module pe_word_tx #(
    parameter WIDTH = 16
) (
    input wire clk_sys,
    input wire nrst,
    input wire load,
    input wire [WIDTH-1:0] word,
    input wire linkFall,
    output reg linkOut,
    output reg linkOe,
    output reg busy
);

    reg [WIDTH-1:0] shiftReg;
    reg [4:0] countReg;

    // msb is on the pin before the first falling edge; the next 15 falling edges advance one bit each, the 16th releases the line
    always @(posedge clk_sys) begin
        if (!nrst) begin
            shiftReg <= {WIDTH{1'b0}};
            countReg <= 5'h00;
            linkOut <= 1'b0;
            linkOe <= 1'b0;
            busy <= 1'b0;
        end else if (load && !busy) begin
            shiftReg <= {word[WIDTH-2:0], 1'b0};
            linkOut <= word[WIDTH-1];
            linkOe <= 1'b1;
            countReg <= 5'h00;
            busy <= 1'b1;
        end else if (busy && linkFall) begin
            if (countReg == WIDTH - 1) begin
                busy <= 1'b0;
                linkOe <= 1'b0;
                linkOut <= 1'b0;
            end else begin
                countReg <= countReg + 5'h01;
                linkOut <= shiftReg[WIDTH-1];
                shiftReg <= {shiftReg[WIDTH-2:0], 1'b0};
            end
        end
    end

endmodule // pe_word_tx

`default_nettype wire

// [pe_query_resp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pe_query_resp_properties #(
    parameter [15:0] KNOWN_OPCODES = 16'hfcff
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic linkClk,
    input wire logic linkDataIn,
    input wire logic linkDataOut,
    input wire logic linkDataOe,
    input wire logic globalCodeProtect,
    input wire logic globalWriteProtect,
    input wire logic codeRdReq,
    input wire logic [23:0] codeRdAddr,
    input wire logic [23:0] codeRdData,
    input wire logic codeRdValid,
    input wire logic execStart,
    input wire logic [3:0] execOpcode,
    input wire logic [15:0] cmdWord,
    input wire logic cmdWordValid,
    input wire logic execDone,
    input wire logic [1:0] execStatus,
    input wire logic respDataReq,
    input wire logic [15:0] respData,
    input wire logic respDataValid,
    input wire logic busyOut
);
    logic [23:0] nextAddr_reg;
    // a response always closes a blank check, so the next check starts from zero again
    always @(posedge clk_sys) begin
        if (!nrst || linkDataOe)
            nextAddr_reg <= 24'h000000;
        else if (codeRdReq)
            nextAddr_reg <= codeRdAddr + 24'h000002;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_addr_sequence: assert property (codeRdReq |-> codeRdAddr == nextAddr_reg)
        else $error("code read address out of sequence");
    a_read_wait: assert property (codeRdReq |=> !codeRdReq until codeRdValid)
        else $error("code read issued before previous answer");
    a_addr_hold: assert property (codeRdReq |=> $stable(codeRdAddr) until codeRdValid)
        else $error("code read address moved while waiting");
    a_exec_known: assert property (execStart |-> KNOWN_OPCODES[execOpcode] &&
        execOpcode != 4'ha && execOpcode != 4'hb)
        else $error("executor started for unknown or query opcode");
    a_quiet_tx: assert property (linkDataOe |-> !codeRdReq && !execStart && !cmdWordValid)
        else $error("new work while response is sent");
    a_tx_busy: assert property (linkDataOe |-> busyOut)
        else $error("response driven while idle");
    a_start_busy: assert property (codeRdReq || execStart |-> busyOut)
        else $error("work started while idle");
    a_resp_req: assert property (respDataReq |-> !linkDataOe ##1 !respDataReq)
        else $error("data word requested during a word");
    a_cmd_spacing: assert property (cmdWordValid |=> !cmdWordValid [*8])
        else $error("command words too close together");
    a_exec_once: assert property (execStart |=> !execStart until execDone)
        else $error("second command started before first done");
    c_read_data: cover property (respDataValid);
    c_exec_fail: cover property (execDone && execStatus == 2'h1);
    c_blank_read: cover property (codeRdReq && codeRdAddr == 24'h000004);
endmodule // pe_query_resp_properties

bind pe_query_resp pe_query_resp_properties #(.KNOWN_OPCODES(KNOWN_OPCODES)) u_props (
    .clk_sys(clk_sys), .nrst(nrst), .linkClk(linkClk), .linkDataIn(linkDataIn),
    .linkDataOut(linkDataOut), .linkDataOe(linkDataOe), .globalCodeProtect(globalCodeProtect),
    .globalWriteProtect(globalWriteProtect), .codeRdReq(codeRdReq), .codeRdAddr(codeRdAddr),
    .codeRdData(codeRdData), .codeRdValid(codeRdValid), .execStart(execStart),
    .execOpcode(execOpcode), .cmdWord(cmdWord), .cmdWordValid(cmdWordValid),
    .execDone(execDone), .execStatus(execStatus), .respDataReq(respDataReq),
    .respData(respData), .respDataValid(respDataValid), .busyOut(busyOut)
);
`default_nettype wire

// [pe_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pe_prog_model (
    output logic linkClk,
    output logic progOut,
    output logic progOe,
    input wire logic pin,
    input wire logic devOe,
    output logic [15:0] rxWord,
    output logic rxStrobe
);
    initial begin
        linkClk = 1'b0;
        progOut = 1'b0;
        progOe = 1'b0;
        rxWord = 16'h0000;
        rxStrobe = 1'b0;
    end
    // data held 100 ns past the rising edge, as the device syncs clock and data alike
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            progOe = 1'b1;
            progOut = w[i];
            #60 linkClk = 1'b1;
            #40 linkClk = 1'b0;
            #60;
        end
        progOe = 1'b0;
    endtask
    // long low phase gives the device time to shift out after each falling edge
    task automatic recv_word(output logic ok);
        int n;
        n = 0;
        while (!devOe && n < 20000) begin
            #10;
            n++;
        end
        ok = devOe;
        #20;
        for (int i = 15; i >= 0; i--) begin
            rxWord[i] = pin;
            linkClk = 1'b1;
            #40 linkClk = 1'b0;
            #120;
        end
        rxStrobe = 1'b1;
        #10 rxStrobe = 1'b0;
    endtask
endmodule // pe_prog_model
`default_nettype wire

// [pe_query_resp_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pe_query_resp_tb;
    localparam logic [7:0] VER = 8'h23; // version 2.3, value arbitrary
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic globalCodeProtect = 1'b1;
    logic globalWriteProtect = 1'b1;
    logic [23:0] codeRdData = 24'h000000;
    logic codeRdValid = 1'b0;
    logic execDone = 1'b0;
    logic [1:0] execStatus = 2'h0;
    logic [15:0] respData = 16'h0000;
    logic respDataValid = 1'b0;
    wire linkClk, progOut, progOe, linkDataOut, linkDataOe, pin, rxStrobe;
    wire codeRdReq, execStart, cmdWordValid, respDataReq, busyOut;
    wire [23:0] codeRdAddr;
    wire [3:0] execOpcode;
    wire [15:0] cmdWord, rxWord;
    logic [23:0] mem [0:15];
    logic [23:0] rdAddrs [$];
    logic [15:0] expQ [$];
    logic [15:0] argQ [$];
    logic [15:0] cmdQ [$];
    logic [3:0] expOp = 4'h0;
    logic [15:0] rw;
    logic [1:0] exStat = 2'h0;
    logic [3:0] ops [6] = '{4'h5, 4'h5, 4'h4, 4'he, 4'hf, 4'h2};
    logic [1:0] sts [6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2};
    int error_cnt = 0;
    int tests_run = 0;
    int rdWait = 0;
    int exWait = 0;
    int dtWait = 0;

    always #10 clk_sys = ~clk_sys;
    // a line nobody drives floats to its pull-up
    assign pin = linkDataOe ? linkDataOut : (progOe ? progOut : 1'b1);

    pe_query_resp #(.VERSION(VER)) u_pe_query_resp (
        .clk_sys(clk_sys), .nrst(nrst), .linkClk(linkClk), .linkDataIn(pin),
        .linkDataOut(linkDataOut), .linkDataOe(linkDataOe),
        .globalCodeProtect(globalCodeProtect), .globalWriteProtect(globalWriteProtect),
        .codeRdReq(codeRdReq), .codeRdAddr(codeRdAddr), .codeRdData(codeRdData),
        .codeRdValid(codeRdValid), .execStart(execStart), .execOpcode(execOpcode),
        .cmdWord(cmdWord), .cmdWordValid(cmdWordValid), .execDone(execDone),
        .execStatus(execStatus), .respDataReq(respDataReq), .respData(respData),
        .respDataValid(respDataValid), .busyOut(busyOut)
    );
    pe_prog_model u_prog (
        .linkClk(linkClk), .progOut(progOut), .progOe(progOe), .pin(pin),
        .devOe(linkDataOe), .rxWord(rxWord), .rxStrobe(rxStrobe)
    );

    // memory, executor and data source answer after a random latency
    always @(negedge clk_sys) begin
        codeRdValid <= rdWait == 1;
        execDone <= exWait == 1;
        respDataValid <= dtWait == 1;
        codeRdData <= mem[codeRdAddr[4:1]];
        execStatus <= exStat;
        rdWait <= codeRdReq ? 1 + $urandom % 4 : (rdWait > 0 ? rdWait - 1 : 0);
        exWait <= execStart ? 1 + $urandom % 6 : (exWait > 0 ? exWait - 1 : 0);
        dtWait <= respDataReq ? 1 + $urandom % 3 : (dtWait > 0 ? dtWait - 1 : 0);
        if (codeRdReq)
            rdAddrs.push_back(codeRdAddr);
        if (cmdWordValid)
            cmp_word("command word", cmdQ.size() ? cmdQ.pop_front() : 16'hxxxx, cmdWord);
        if (execStart)
            cmp_word("exec opcode", {12'h000, expOp}, {12'h000, execOpcode});
        if (respDataReq) begin
            rw = 16'($urandom);
            respData <= rw;
            expQ.push_back(rw);
        end
    end

    task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_addr(input string what, input logic [23:0] e, input logic [23:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge rxStrobe)
        cmp_word("response word", expQ.size() ? expQ.pop_front() : 16'hxxxx, rxWord);

    task automatic run(input logic [15:0] w0, input logic [15:0] e0, input logic [15:0] e1);
        logic ok;
        int len;
        expQ.push_back(e0);
        expQ.push_back(e1);
        expOp = w0[15:12];
        cmdQ.push_back(w0);
        foreach (argQ[i])
            cmdQ.push_back(argQ[i]);
        u_prog.send_word(w0);
        foreach (argQ[i])
            u_prog.send_word(argQ[i]);
        argQ.delete();
        len = 2;
        for (int i = 0; i < len && i < 64; i++) begin
            u_prog.recv_word(ok);
            if (!ok) begin
                error_cnt++;
                $display("ERROR response wait timed out");
                tally_and_finish();
            end
            if (i == 1)
                len = rxWord;
        end
        @(negedge clk_sys);
        cmp_word("words left over", 16'h0000, 16'(expQ.size() + cmdQ.size()));
    endtask

    initial begin
        int n;
        logic [7:0] qe;
        n = $urandom(54800);
        foreach (mem[i])
            mem[i] = 24'hffffff;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        run(16'hb001, {4'h1, 4'hb, VER}, 16'h0002);
        run(16'hb000, {4'h1, 4'hb, VER}, 16'h0002);
        // blank, bit cleared inside the range, then each protect bit cleared
        for (int k = 0; k < 4; k++) begin
            n = k < 2 ? 3 : 0;
            foreach (mem[i])
                mem[i] = 24'hffffff;
            mem[k == 0 ? 3 : $urandom % 3] = 24'h7fffff;
            @(negedge clk_sys);
            globalCodeProtect = k != 2;
            globalWriteProtect = k != 3;
            argQ = '{16'(n), 16'($urandom % 2049)};
            run(16'ha003, {8'h1a, k == 0 ? 8'hf0 : 8'h0f}, 16'h0002);
            cmp_addr("read count", 24'(n), 24'(rdAddrs.size()));
            foreach (rdAddrs[i])
                cmp_addr("read address", 24'(2 * i), rdAddrs[i]);
            rdAddrs.delete();
        end
        @(negedge clk_sys);
        globalCodeProtect = 1'b1;
        globalWriteProtect = 1'b1;
        for (int k = 8; k < 10; k++) begin
            argQ = '{16'($urandom)};
            run({4'(k), 12'h002}, {4'h3, 4'(k), 8'h00}, 16'h0002);
        end
        for (int k = 0; k < 6; k++) begin
            exStat = sts[k];
            n = k == 0 ? 16'h33 : 4;
            repeat (n - 1)
                argQ.push_back(16'($urandom));
            qe = sts[k] == 0 ? 8'h00 : (sts[k] == 1 && ops[k] inside {4'h4, 4'h5} ? 8'h01 : 8'h02);
            run({ops[k], 12'(n)}, {sts[k] == 0 ? 4'h1 : 4'h2, ops[k], qe}, 16'h0002);
        end
        exStat = 2'h0;
        for (int k = 0; k < 2; k++) begin
            n = 2 * (1 + $urandom % 3) - k;
            argQ = '{16'(n), 16'h0000, 16'h0000};
            run(16'h2004, 16'h1200, 16'(n % 2 ? 3 * (n + 1) / 2 + 2 : 3 * n / 2 + 2));
        end
        tally_and_finish();
    end
endmodule // pe_query_resp_tb
`default_nettype wire
